// file: lps_power_cmd_fsm.sv
// power-state and command-acceptance tracker of a low-power ddr2 memory.
// link side runs on ck from the controller; clk is a free-running clock.

`timescale 1ns/1ps
`default_nettype none

module lps_power_cmd_fsm import lps_pkg::*; (
	// system clock
	input wire logic clk,
	input wire logic rst_b,
	// link from controller
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_b,
	input wire logic [CA_W-1:0] ca,
	// status on the link clock
	output var lps_pwr_t power_state,
	output logic [NUM_BANKS-1:0] bank_open,
	output logic rd_burst,
	output logic wr_burst,
	output logic [BA_W-1:0] burst_bank,
	output logic [COL_W-1:0] col_addr,
	output logic illegal_cmd,
	output logic deep_sleep_state,
	// status on the system clock
	output logic wake_req,
	output logic init_done
);

	typedef struct packed {
		logic rs1;
		logic rs2;
		logic id1;
		logic id2;
		lps_pwr_t pwr;
		lps_bank_t [NUM_BANKS-1:0] banks;
		logic [NUM_BANKS-1:0] ap;
		logic [BA_W-1:0] bb;
		logic live;
		logic ill;
		logic tgl;
		logic slp;
		logic [COL_W-1:0] col;
	} lps_link_t;

	typedef struct packed {
		logic ck1;
		logic ck2;
		logic lp1;
		logic lp2;
		logic rt1;
		logic rt2;
		logic rt3;
		logic [INIT_CW-1:0] cnt;
		logic done;
		logic wake;
	} lps_sys_t;

	lps_link_t st_r, st_nxt;
	lps_sys_t sy_r, sy_nxt;
	logic cap_cs_b, cap_cke, cap_ckep;
	logic [CA_W-1:0] rise, fall;
	lps_cmd_t cmd;
	logic [BA_W-1:0] ba;
	logic [7:0] ma;
	logic is_reset;

	// ==========================================
	// decode helpers
	function automatic lps_cmd_t cmd_of(input logic [3:0] c);
		if (!c[0] && !c[1])
			cmd_of = c[2] ? (c[3] ? C_REFAB : C_REFPB)
				: (c[3] ? C_MRR : C_MRW);
		else if (!c[0])
			cmd_of = C_ACT;
		else if (!c[1])
			cmd_of = c[2] ? C_RD : C_WR;
		else
			cmd_of = c[2] ? C_NOP : (c[3] ? C_PRE : C_BST);
	endfunction

	function automatic logic all_idle(
		input lps_bank_t [NUM_BANKS-1:0] b
	);
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (b[i] != B_IDLE)
				all_idle = 1'b0;
		end
	endfunction

	// ==========================================
	// pin capture on the link clock
	lps_capture u_cap (
		.ck(ck),
		.ck_rst_b(st_r.rs2),
		.cs_b(cs_b),
		.cke(cke),
		.ca(ca),
		.cs_b_r(cap_cs_b),
		.cke_r(cap_cke),
		.cke_prev_r(cap_ckep),
		.ca_bit_rise_sample(rise),
		.ca_bit_fall_sample(fall)
	);

	assign cmd = cmd_of(rise[3:0]);
	// bank bits travel with the command
	assign ba = rise[BA_LSB +: BA_W];
	assign ma = {fall[1:0], rise[MA_LSB +: 6]};
	assign is_reset = (cmd == C_MRW) && (ma == RESET_MA);

	// ==========================================
	// link-side state machine
	always_comb begin
		st_nxt = st_r;
		// reset is re-timed here; first flop only feeds the second
		st_nxt.rs1 = rst_b;
		st_nxt.rs2 = st_r.rs1;
		st_nxt.id1 = sy_r.done;
		st_nxt.id2 = st_r.id1;
		st_nxt.ill = 1'b0;
		if (!cap_ckep && !cap_cke) begin
			st_nxt.pwr = st_r.pwr;
		end else if (!cap_ckep) begin
			if (!cap_cs_b) begin
				st_nxt.ill = 1'b1;
			end else begin
				unique case (st_r.pwr)
					P_ACTIVE_PD, P_IDLE_PD: begin
						st_nxt.pwr = P_READY;
					end
					P_RESET_PD: begin
						st_nxt.pwr = st_r.id2 ? P_READY : P_RESETTING;
					end
					// cke rising after power-up is no wake: not illegal
					P_POWER_ON: begin
						st_nxt.pwr = P_POWER_ON;
					end
					P_DEEP_SLEEP: begin
						st_nxt.pwr = P_POWER_ON;
					end
					P_SELF_REF: begin
						st_nxt.pwr = P_READY;
					end
					default: begin
						st_nxt.ill = 1'b1;
					end
				endcase
			end
		end else if (!cap_cke) begin
			if (cap_cs_b) begin
				if (st_r.pwr == P_READY)
					st_nxt.pwr = all_idle(st_r.banks) ? P_IDLE_PD
						: P_ACTIVE_PD;
				else if (st_r.pwr == P_RESETTING)
					st_nxt.pwr = P_RESET_PD;
				else
					st_nxt.ill = 1'b1;
			end else if (st_r.pwr == P_READY && all_idle(st_r.banks)
				&& (cmd == C_REFPB || cmd == C_REFAB)) begin
				st_nxt.pwr = P_SELF_REF;
			end else if (st_r.pwr == P_READY && all_idle(st_r.banks)
				&& (cmd == C_PRE || cmd == C_BST)) begin
				st_nxt.pwr = P_DEEP_SLEEP;
			end else begin
				st_nxt.ill = 1'b1;
			end
		end else if (cap_cs_b || cmd == C_NOP) begin
			st_nxt.pwr = st_r.pwr;
		end else begin
			unique case (st_r.pwr)
				P_POWER_ON: begin
					if (is_reset) begin
						st_nxt.pwr = P_RESETTING;
						st_nxt.tgl = ~st_r.tgl;
					end else begin
						st_nxt.ill = 1'b1;
					end
				end
				P_RESETTING: begin
					if (is_reset)
						st_nxt.tgl = ~st_r.tgl;
					else if (cmd != C_MRR)
						st_nxt.ill = 1'b1;
				end
				P_READY: begin
					unique case (cmd)
						C_ACT: begin
							if (st_r.banks[ba] == B_IDLE)
								st_nxt.banks[ba] = B_ACTIVE;
							else
								st_nxt.ill = 1'b1;
						end
						C_REFPB: begin
							if (BANKS_CFG != 8 || st_r.live)
								st_nxt.ill = 1'b1;
						end
						C_REFAB: begin
							if (!all_idle(st_r.banks))
								st_nxt.ill = 1'b1;
						end
						C_MRW: begin
							if (!all_idle(st_r.banks)) begin
								st_nxt.ill = 1'b1;
							end else if (is_reset) begin
								st_nxt.pwr = P_RESETTING;
								st_nxt.tgl = ~st_r.tgl;
							end
						end
						C_MRR: begin
							if (st_r.live)
								st_nxt.ill = 1'b1;
						end
						C_PRE: begin
							for (int i = 0; i < NUM_BANKS; i++) begin
								if (rise[AB_BIT] || ba == BA_W'(i)) begin
									st_nxt.banks[i] = B_IDLE;
									st_nxt.ap[i] = 1'b0;
								end
							end
							if (rise[AB_BIT] || ba == st_r.bb)
								st_nxt.live = 1'b0;
						end
						// new burst ends the old one
						C_RD, C_WR: begin
							if (st_r.banks[ba] == B_IDLE) begin
								st_nxt.ill = 1'b1;
							end else begin
								if (st_r.live) begin
									st_nxt.banks[st_r.bb] =
										st_r.ap[st_r.bb] ? B_IDLE
										: B_ACTIVE;
									st_nxt.ap[st_r.bb] = 1'b0;
								end
								st_nxt.banks[ba] = (cmd == C_RD)
									? B_READING : B_WRITING;
								st_nxt.ap[ba] = fall[AP_BIT];
								st_nxt.bb = ba;
								st_nxt.live = 1'b1;
								st_nxt.col = {fall[9:1],
									rise[COL1_BIT +: 2], COL0_VALUE};
							end
						end
						C_BST: begin
							if (st_r.live) begin
								st_nxt.banks[st_r.bb] =
									st_r.ap[st_r.bb] ? B_IDLE
									: B_ACTIVE;
								st_nxt.ap[st_r.bb] = 1'b0;
								st_nxt.live = 1'b0;
							end else begin
								st_nxt.ill = 1'b1;
							end
						end
						default: begin
							st_nxt.ill = 1'b1;
						end
					endcase
				end
				default: begin
					st_nxt.ill = 1'b1;
				end
			endcase
		end
		st_nxt.slp = (st_nxt.pwr == P_SELF_REF)
			|| (st_nxt.pwr == P_DEEP_SLEEP);
		if (!st_r.rs2) begin
			st_nxt = '0;
			st_nxt.rs1 = rst_b;
			st_nxt.rs2 = st_r.rs1;
			st_nxt.pwr = P_POWER_ON;
		end
	end

	always_ff @(posedge ck) begin
		st_r <= st_nxt;
	end

	// ==========================================
	// system-clock side: wake detect and init timer
	always_comb begin
		sy_nxt = sy_r;
		sy_nxt.ck1 = cke;
		sy_nxt.ck2 = sy_r.ck1;
		sy_nxt.lp1 = st_r.slp;
		sy_nxt.lp2 = sy_r.lp1;
		sy_nxt.rt1 = st_r.tgl;
		sy_nxt.rt2 = sy_r.rt1;
		sy_nxt.rt3 = sy_r.rt2;
		sy_nxt.wake = sy_r.ck2 && sy_r.lp2;
		// restart on each reset command
		if (sy_r.rt2 != sy_r.rt3) begin
			sy_nxt.cnt = INIT_CW'(INIT_CYC);
			sy_nxt.done = 1'b0;
		end else if (sy_r.cnt != '0) begin
			sy_nxt.cnt = sy_r.cnt - 1'b1;
			sy_nxt.done = (sy_r.cnt == INIT_CW'(1));
		end
		if (!rst_b)
			sy_nxt = '0;
	end

	always_ff @(posedge clk) begin
		sy_r <= sy_nxt;
	end

	// ==========================================
	// outputs
	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++)
			bank_open[i] = (st_r.banks[i] != B_IDLE);
	end

	assign power_state = st_r.pwr;
	assign rd_burst = st_r.live && (st_r.banks[st_r.bb] == B_READING);
	assign wr_burst = st_r.live && (st_r.banks[st_r.bb] == B_WRITING);
	assign burst_bank = st_r.bb;
	assign col_addr = st_r.col;
	assign illegal_cmd = st_r.ill;
	assign deep_sleep_state = (st_r.pwr == P_DEEP_SLEEP);
	assign wake_req = sy_r.wake;
	assign init_done = sy_r.done;

	// ==========================================
	// checks
	// hold in low power
	hold_lp_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(!cap_ckep && !cap_cke) |=> $stable(power_state)
	) else $error("state moved with clock enable low");

	pd_exit_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(power_state == P_ACTIVE_PD && !cap_ckep && cap_cke && cap_cs_b)
		|=> power_state == P_READY && bank_open != '0
	) else $error("active power-down exit went wrong");

	deep_exit_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(deep_sleep_state && !cap_ckep && cap_cke && cap_cs_b)
		|=> power_state == P_POWER_ON
	) else $error("deep sleep exit missed power-on");

	pd_entry_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(power_state == P_READY && cap_ckep && !cap_cke && cap_cs_b)
		|=> power_state == (($past(bank_open) == '0) ? P_IDLE_PD
			: P_ACTIVE_PD)
	) else $error("wrong power-down entered");

	sref_entry_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(power_state == P_READY && bank_open == '0 && cap_ckep
		&& !cap_cke && !cap_cs_b && cmd inside {C_REFPB, C_REFAB})
		|=> power_state == P_SELF_REF ##1 !illegal_cmd [*1]
	) else $error("self refresh not entered");

	bst_end_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(power_state == P_READY && cap_ckep && cap_cke && !cap_cs_b
		&& cmd == C_BST && st_r.live)
		|=> !rd_burst && !wr_burst && !illegal_cmd
			&& burst_bank == $past(burst_bank)
	) else $error("burst terminate missed the burst");

	nop_hold_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(cap_ckep && cap_cke && cap_cs_b)
		|=> $stable(power_state) && $stable(bank_open) && !illegal_cmd
	) else $error("deselect changed the state");

	bad_cmd_a: assert property (
		@(posedge ck) disable iff (!st_r.rs2)
		(power_state == P_POWER_ON && cap_ckep && cap_cke && !cap_cs_b
		&& cmd != C_NOP && !is_reset)
		|=> illegal_cmd && power_state == P_POWER_ON
	) else $error("illegal command not flagged");

	wake_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(sy_r.ck2 && sy_r.lp2) |=> wake_req
	) else $error("wake not raised on exit");

endmodule

`default_nettype wire

// file: lps_capture.sv
// lps_pkg: shared constants and types for the power-state command block.
// lps_capture: pin capture of the command/address link on the link clock.
// assumes the controller drives cs_b, cke and ca synchronous to ck.

package lps_pkg;
	localparam int NUM_BANKS = 8;
	localparam int BANKS_CFG = 8;
	localparam int CA_W = 10;
	localparam int BA_W = 3;
	localparam int COL_W = 12;
	// field positions on the two edges
	localparam int AP_BIT = 0;
	localparam int AB_BIT = 4;
	localparam int BA_LSB = 7;
	localparam int MA_LSB = 4;
	localparam int COL1_BIT = 5;
	localparam logic [7:0] RESET_MA = 8'h3F;
	localparam logic COL0_VALUE = 1'b0;
	// reset values of the link-side samples
	localparam logic CKE_RST = 1'b0;
	localparam logic CS_RST = 1'b1;
	// final initialisation interval, plain default
	localparam int T_INIT_DONE_NS = 1000;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int INIT_CYC =
		(T_INIT_DONE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_CW = $clog2(INIT_CYC + 1);

	typedef enum logic [3:0] {
		C_NOP, C_MRW, C_MRR, C_REFPB, C_REFAB, C_ACT,
		C_WR, C_RD, C_PRE, C_BST
	} lps_cmd_t;

	typedef enum logic [2:0] {
		P_POWER_ON, P_RESETTING, P_RESET_PD, P_READY,
		P_IDLE_PD, P_ACTIVE_PD, P_SELF_REF, P_DEEP_SLEEP
	} lps_pwr_t;

	typedef enum logic [1:0] {
		B_IDLE, B_ACTIVE, B_READING, B_WRITING
	} lps_bank_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module lps_capture import lps_pkg::*; (
	// link clock and its synchronous reset
	input wire logic ck,
	input wire logic ck_rst_b,
	// link pins
	input wire logic cs_b,
	input wire logic cke,
	input wire logic [CA_W-1:0] ca,
	// held samples
	output logic cs_b_r,
	output logic cke_r,
	output logic cke_prev_r,
	output logic [CA_W-1:0] ca_bit_rise_sample,
	output logic [CA_W-1:0] ca_bit_fall_sample
);

	// ==========================================
	// rising edge: select, clock enable, ca
	// rising-edge only sampling
	always_ff @(posedge ck) begin
		if (!ck_rst_b) begin
			cs_b_r <= CS_RST;
			cke_r <= CKE_RST;
			cke_prev_r <= CKE_RST;
			ca_bit_rise_sample <= '0;
		end else begin
			cs_b_r <= cs_b;
			cke_r <= cke;
			cke_prev_r <= cke_r;
			ca_bit_rise_sample <= ca;
		end
	end

	// ==========================================
	// falling edge: second half of ca only
	// falling half of ca
	always_ff @(negedge ck) begin
		if (!ck_rst_b) begin
			ca_bit_fall_sample <= '0;
		end else begin
			ca_bit_fall_sample <= ca;
		end
	end

endmodule

`default_nettype wire

// file: lps_ctrl_model.sv
// lps_ctrl_model: memory-controller stand-in driving the link pins.
// assumes one caller at a time; ck stands still at 0 between calls.
`timescale 1ns/1ps
`default_nettype none

module lps_ctrl_model import lps_pkg::*; (
	// link pins
	output logic ck,
	output logic cke,
	output logic cs_b,
	output logic [CA_W-1:0] ca
);
	initial begin
		ck = 1'b0;
		cke = 1'b1;
		cs_b = 1'b1;
		ca = 10'h000;
	end

	// ==========================================
	// one link cycle, rise half then fall half
	task automatic cyc(input logic k, input logic s,
		input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
		cke = k;
		cs_b = s;
		ca = r;
		#3.75 ck = 1'b1;
		#3.75 ca = f;
		#3.75 ck = 1'b0;
		// hold over: inverse so stale bits never look valid
		#0.5 ca = ~f;
		#3.25;
	endtask

	task automatic nop(input logic k);
		cyc(k, 1'b1, 10'h007, 10'h000);
	endtask

	task automatic wake();
		cke = 1'b1;
	endtask
endmodule

`default_nettype wire

// file: tb_lps_power_cmd_fsm.sv
// tb_lps_power_cmd_fsm: self-checking bench for the power-state tracker.
// assumes lps_pkg, lps_capture and the design top are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_lps_power_cmd_fsm import lps_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	wire logic ck;
	wire logic cke;
	wire logic cs_b;
	wire logic [CA_W-1:0] ca;
	lps_pwr_t power_state;
	logic [NUM_BANKS-1:0] bank_open;
	logic rd_burst;
	logic wr_burst;
	logic [BA_W-1:0] burst_bank;
	logic [COL_W-1:0] col_addr;
	logic illegal_cmd;
	logic deep_sleep_state;
	logic wake_req;
	logic init_done;
	int errors = 0;
	int num_checks = 0;
	logic [13:0] exp_q[$];
	lps_pwr_t ps;
	logic [7:0] bo;
	logic rd;
	logic wr;
	logic [2:0] b;
	logic [2:0] c;
	logic [8:0] colf;
	logic [1:0] colr;

	always #12.5 clk = ~clk;

	lps_ctrl_model u_lps_ctrl_model (.ck(ck), .cke(cke), .cs_b(cs_b),
		.ca(ca));

	lps_power_cmd_fsm u_lps_power_cmd_fsm (.clk(clk), .rst_b(rst_b),
		.ck(ck), .cke(cke), .cs_b(cs_b), .ca(ca),
		.power_state(power_state), .bank_open(bank_open),
		.rd_burst(rd_burst), .wr_burst(wr_burst),
		.burst_bank(burst_bank), .col_addr(col_addr),
		.illegal_cmd(illegal_cmd), .deep_sleep_state(deep_sleep_state),
		.wake_req(wake_req), .init_done(init_done));

	// ==========================================
	// checking
	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// status answers one link cycle after the command's rise edge
	always @(posedge ck) begin
		#1;
		if (exp_q.size() > 0) begin
			chk("status", {2'b00, power_state, bank_open, rd_burst,
				wr_burst, illegal_cmd}, {2'b00, exp_q.pop_front()});
		end
	end

	// send a command and note the status it should leave
	task automatic op(input logic k, input logic s,
		input logic [CA_W-1:0] r, input logic [CA_W-1:0] f,
		input logic ill);
		u_lps_ctrl_model.cyc(k, s, r, f);
		exp_q.push_back({ps, bo, rd, wr, ill});
	endtask

	task automatic wait_hi(input string name, ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(name, {15'h0000, s}, 16'h0001);
		if (s !== 1'b1) begin
			end_of_test();
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(48690));
		ps = P_POWER_ON;
		bo = 8'h00;
		rd = 1'b0;
		wr = 1'b0;
		b = 3'($urandom);
		c = b ^ 3'h1;
		colf = 9'($urandom);
		colr = 2'($urandom);
		fork
			repeat (8) @(posedge clk);
			repeat (12) u_lps_ctrl_model.nop(1'b1);
		join
		chk("reset", 16'({power_state, bank_open, wake_req, init_done}),
			16'({P_POWER_ON, 10'h000}));
		@(posedge clk);
		#2 rst_b = 1'b1;
		repeat (5) u_lps_ctrl_model.nop(1'b1);
		op(1, 0, {b, 7'h02}, 0, 1);
		ps = P_RESETTING;
		op(1, 0, 10'h3F0, 0, 0);
		op(1, 0, 10'h008, 0, 0);
		ps = P_RESET_PD;
		op(0, 1, 10'h007, 0, 0);
		ps = P_RESETTING;
		op(1, 1, 10'h007, 0, 0);
		ps = P_RESET_PD;
		op(0, 1, 10'h007, 0, 0);
		wait_hi("init_done", init_done, 80);
		repeat (4) op(0, 0, 10'h3F0, 0, 0);
		ps = P_READY;
		op(1, 1, 10'h007, 0, 0);
		u_lps_ctrl_model.nop(1'b1);
		$display("test init done");
		op(1, 0, {b, 7'h05}, 0, 1);
		op(1, 0, 10'h004, 0, 0);
		op(1, 0, 10'h00C, 0, 0);
		bo[b] = 1'b1;
		op(1, 0, {b, 7'h02}, 0, 0);
		bo[c] = 1'b1;
		op(1, 0, {c, 7'h02}, 0, 0);
		rd = 1'b1;
		op(1, 0, {b, colr, 5'h05}, {colf, 1'b0}, 0);
		u_lps_ctrl_model.nop(1'b1);
		chk("col", 16'(col_addr), {4'h0, colf, colr, 1'b0});
		chk("bank", 16'(burst_bank), 16'(b));
		rd = 1'b0;
		wr = 1'b1;
		op(1, 0, {c, 7'h01}, 10'h001, 0);
		bo[c] = 1'b0;
		wr = 1'b0;
		op(1, 0, 10'h003, 0, 0);
		rd = 1'b1;
		op(1, 0, {b, 7'h05}, 0, 0);
		rd = 1'b0;
		wr = 1'b1;
		op(1, 0, {b, 7'h01}, 0, 0);
		rd = 1'b1;
		wr = 1'b0;
		op(1, 0, {b, 7'h05}, 0, 0);
		rd = 1'b0;
		op(1, 0, 10'h003, 0, 0);
		op(1, 1, 10'h3FF, 10'h155, 0);
		op(1, 0, 10'h007, 0, 0);
		$display("test banks done");
		ps = P_ACTIVE_PD;
		op(0, 1, 10'h007, 0, 0);
		op(0, 0, 10'h004, 0, 0);
		ps = P_READY;
		op(1, 1, 10'h007, 0, 0);
		u_lps_ctrl_model.nop(1'b1);
		bo = 8'h00;
		op(1, 0, {b, 3'b001, 4'hB}, 0, 0);
		ps = P_IDLE_PD;
		op(0, 1, 10'h007, 0, 0);
		ps = P_READY;
		op(1, 1, 10'h007, 0, 0);
		u_lps_ctrl_model.nop(1'b1);
		$display("test power-down done");
		ps = P_SELF_REF;
		op(0, 0, 10'h004, 0, 0);
		op(0, 1, 10'h007, 0, 0);
		u_lps_ctrl_model.wake();
		wait_hi("wake_req", wake_req, 12);
		ps = P_READY;
		op(1, 1, 10'h007, 0, 0);
		repeat (2) u_lps_ctrl_model.nop(1'b1);
		ps = P_DEEP_SLEEP;
		op(0, 0, 10'h003, 0, 0);
		op(0, 1, 10'h007, 0, 0);
		chk("deep", 16'(deep_sleep_state), 16'h0001);
		repeat (8) @(posedge clk);
		u_lps_ctrl_model.wake();
		wait_hi("wake_req", wake_req, 12);
		ps = P_POWER_ON;
		op(1, 1, 10'h007, 0, 0);
		u_lps_ctrl_model.nop(1'b1);
		chk("drain", 16'(exp_q.size()), 16'h0000);
		$display("test sleep done");
		end_of_test();
	end
endmodule

`default_nettype wire
